// *** include/pdr_regs.vh ***
// Purpose: constants of the port data register block
// Assumes: byte addressing on a 32-bit Avalon-MM slave
// Notes:   definitions only
`ifndef PDR_REGS_VH
`define PDR_REGS_VH

// register byte addresses, one aligned word each
`define PDR_ADDR_A     4'h0
`define PDR_ADDR_B     4'h4
`define PDR_ADDR_C     4'h8

// reset value of every data register
`define PDR_RST_DATA   16'h0000
`define PDR_RST_WORD   32'h0000_0000

// per-pin two-bit mode codes
`define PDR_MODE_IN    2'h0
`define PDR_MODE_OUT   2'h1
`define PDR_MODE_RSV   2'h2
`define PDR_MODE_ALT   2'h3

// field layout of a data word
`define PDR_LANE0_LSB  0
`define PDR_LANE1_LSB  8
`define PDR_LANE_W     8

`endif

// *** logic/pdr_pin_bank.v ***
// Purpose: pin drive, weak keeper and read select for one port
// Assumes: modes come from the pin function controller, pin is sampled
// Notes:   output enable is active low
`default_nettype none
`timescale 1ns/1ps
`include "pdr_regs.vh"

module pdr_pin_bank #(
   parameter W = 16
) (
   // clock and power-on reset
   input  wire           clk_i,
   input  wire           reset_i,
   // per-pin modes and data
   input  wire [2*W-1:0] mode_i,
   input  wire [W-1:0]   data_i,
   input  wire [W-1:0]   alt_out_i,
   input  wire [W-1:0]   pin_smp_i,
   // pin side
   output reg  [W-1:0]   pin_o,
   output reg  [W-1:0]   pin_oe_n_o,
   output reg  [W-1:0]   keep_o,
   // value a read returns
   output reg  [W-1:0]   rd_o
);

   reg [2*W-1:0] mode_q;
   integer       i;
   integer       j;

   // two-bit mode of pin k in a packed mode vector
   function [1:0] pin_mode;
      input [2*W-1:0] modes;
      input integer   k;
      begin
         pin_mode = modes[2*k +: 2];
      end
   endfunction

   // drivers and keeper follow the mode, one flop later
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         mode_q     <= {2*W{1'b0}};
         pin_o      <= {W{1'b0}};
         pin_oe_n_o <= {W{1'b1}};
         keep_o     <= {W{1'b0}};
      end else begin
         mode_q <= mode_i;
         for (i = 0; i < W; i = i + 1) begin
            // drive only in output or alternate mode
            if (pin_mode(mode_i, i) == `PDR_MODE_OUT) begin
               pin_o[i]      <= data_i[i];
               pin_oe_n_o[i] <= 1'b0;
            end else if (pin_mode(mode_i, i) == `PDR_MODE_ALT) begin
               pin_o[i]      <= alt_out_i[i];
               pin_oe_n_o[i] <= 1'b0;
            end else begin
               pin_o[i]      <= 1'b0;
               pin_oe_n_o[i] <= 1'b1;
            end
            // keeper holds the level across function changes
            if (pin_mode(mode_i, i) == `PDR_MODE_ALT &&
                pin_mode(mode_q, i) == `PDR_MODE_IN)
               keep_o[i] <= alt_out_i[i];
            else if (pin_mode(mode_i, i) == `PDR_MODE_IN &&
                     pin_mode(mode_q, i) == `PDR_MODE_ALT)
               keep_o[i] <= data_i[i];
            else if (pin_mode(mode_i, i) == `PDR_MODE_OUT)
               keep_o[i] <= data_i[i];
            else if (pin_mode(mode_i, i) == `PDR_MODE_ALT)
               keep_o[i] <= alt_out_i[i];
         end
      end
   end

   // stored value in output mode, pin level otherwise
   always @* begin
      rd_o = pin_smp_i;
      for (j = 0; j < W; j = j + 1) begin
         if (pin_mode(mode_i, j) == `PDR_MODE_OUT)
            rd_o[j] = data_i[j];
      end
   end

endmodule // pdr_pin_bank
`default_nettype wire

// *** logic/pdr_port_data.v ***
// Purpose: data registers of ports a, b and c on an Avalon-MM slave
// Assumes: pin inputs synchronous to core_clk_i, modes from outside
// Notes:   one wait state per access, registers in the low 16 bits
`default_nettype none
`timescale 1ns/1ps
`include "pdr_regs.vh"

// Notes on behaviour
// - after a pin goes from alternate output to port input the keeper holds its stored data bit.
// - after a pin goes from port input to alternate output the keeper holds the alternate output value.
// - port a data holds 15 read/write bits, bit k for pin k.
// - bit 15 of port a data reads as zero and software writes zero there.
// - port b data holds 9 read/write bits, bit k for pin k.
// - bits 15 to 9 of port b data read as zero and software writes zero there.
// - power-on reset clears every data register.
// - data registers keep their contents through manual reset, standby and sleep.
// - in input mode a read gives the pin level and a write only stores.
// - in output mode a read gives the stored value.
// - in output mode a write stores the value and drives it on the pin.
// - in alternate mode a read gives the pin level and a write only stores.
// - port c has sixteen two-way pins, each with its own mode.
// - mode 00 is input, 01 output, 11 alternate, and 10 is never selected.
module pdr_port_data #(
   parameter WA = 15,
   parameter WB = 9,
   parameter WC = 16
) (
   // clock and power-on reset
   input  wire            core_clk_i,
   input  wire            reset_i,
   // avalon-mm slave
   input  wire [3:0]      avs_address_i,
   input  wire            avs_read_i,
   input  wire            avs_write_i,
   input  wire [31:0]     avs_writedata_i,
   input  wire [3:0]      avs_byteenable_i,
   output reg  [31:0]     avs_readdata_o,
   output reg             avs_waitrequest_o,
   // port a
   input  wire [2*WA-1:0] pa_mode_i,
   input  wire [WA-1:0]   pa_alt_out_i,
   input  wire [WA-1:0]   pa_pin_i,
   output wire [WA-1:0]   pa_pin_o,
   output wire [WA-1:0]   pa_pin_oe_n_o,
   output wire [WA-1:0]   pa_keep_o,
   // port b
   input  wire [2*WB-1:0] pb_mode_i,
   input  wire [WB-1:0]   pb_alt_out_i,
   input  wire [WB-1:0]   pb_pin_i,
   output wire [WB-1:0]   pb_pin_o,
   output wire [WB-1:0]   pb_pin_oe_n_o,
   output wire [WB-1:0]   pb_keep_o,
   // port c
   input  wire [2*WC-1:0] pc_mode_i,
   input  wire [WC-1:0]   pc_alt_out_i,
   input  wire [WC-1:0]   pc_pin_i,
   output wire [WC-1:0]   pc_pin_o,
   output wire [WC-1:0]   pc_pin_oe_n_o,
   output wire [WC-1:0]   pc_keep_o
);

   // stored data, pin samples and read values
   reg  [WA-1:0] pa_data_q;
   reg  [WA-1:0] pa_data_d;
   reg  [WB-1:0] pb_data_q;
   reg  [WB-1:0] pb_data_d;
   reg  [WC-1:0] pc_data_q;
   reg  [WC-1:0] pc_data_d;
   reg  [WA-1:0] pa_smp_q;
   reg  [WB-1:0] pb_smp_q;
   reg  [WC-1:0] pc_smp_q;
   wire [WA-1:0] pa_rd;
   wire [WB-1:0] pb_rd;
   wire [WC-1:0] pc_rd;
   reg  [15:0]   pa_word;
   reg  [15:0]   pb_word;
   reg  [15:0]   pc_word;
   // bus state
   reg           wait_d;
   reg  [31:0]   rdata_d;
   reg           wr_go;
   reg           rd_go;
   wire [15:0]   wmask;
   reg           wr_a;
   reg           wr_b;
   reg           wr_c;
   wire          hit_a;
   wire          hit_b;
   wire          hit_c;

   // bit mask of the two low byte lanes
   function [15:0] lane_mask;
      input [3:0] be;
      begin
         lane_mask = 16'h0000;
         if (be[0])
            lane_mask[`PDR_LANE0_LSB +: `PDR_LANE_W] = 8'hFF;
         if (be[1])
            lane_mask[`PDR_LANE1_LSB +: `PDR_LANE_W] = 8'hFF;
      end
   endfunction

   // merge write data into old contents under a mask
   function [15:0] merge16;
      input [15:0] old;
      input [15:0] wd;
      input [15:0] msk;
      begin
         merge16 = (old & ~msk) | (wd & msk);
      end
   endfunction

   // true when the bus address selects one register word
   function addr_hit;
      input [3:0] adr;
      input [3:0] sel;
      begin
         addr_hit = (adr == sel);
      end
   endfunction

   // byte lanes enabled on this access
   assign wmask = lane_mask(avs_byteenable_i);

   // register word selected by the address
   assign hit_a = addr_hit(avs_address_i, `PDR_ADDR_A);
   assign hit_b = addr_hit(avs_address_i, `PDR_ADDR_B);
   assign hit_c = addr_hit(avs_address_i, `PDR_ADDR_C);

   // one wait state per access; read data is loaded one edge early
   // so that it already stands at the edge that sees waitrequest low
   // a read is answered in the cycle after the request first shows
   always @* begin
      rd_go = avs_read_i & avs_waitrequest_o;
   end

   // a write takes effect at the edge that sees waitrequest low
   always @* begin
      wr_go = avs_write_i & ~avs_waitrequest_o;
   end

   // waitrequest drops for one cycle per request
   always @* begin
      wait_d = ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
   end

   // write strobe of each data register
   always @* begin
      wr_a = wr_go & hit_a;
      wr_b = wr_go & hit_b;
      wr_c = wr_go & hit_c;
   end

   // pin levels taken into a register for reads
   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         pa_smp_q <= {WA{1'b0}};
         pb_smp_q <= {WB{1'b0}};
         pc_smp_q <= {WC{1'b0}};
      end else begin
         pa_smp_q <= pa_pin_i;
         pb_smp_q <= pb_pin_i;
         pc_smp_q <= pc_pin_i;
      end
   end

   // next value of port a data, stored in every mode
   always @* begin
      pa_word = `PDR_RST_DATA;
      pa_word[WA-1:0] = pa_data_q;
      pa_word = merge16(pa_word, avs_writedata_i[15:0], wmask);
      pa_data_d = pa_data_q;
      if (wr_a)
         pa_data_d = pa_word[WA-1:0];
   end

   // next value of port b data
   always @* begin
      pb_word = `PDR_RST_DATA;
      pb_word[WB-1:0] = pb_data_q;
      pb_word = merge16(pb_word, avs_writedata_i[15:0], wmask);
      pb_data_d = pb_data_q;
      if (wr_b)
         pb_data_d = pb_word[WB-1:0];
   end

   // next value of port c data
   always @* begin
      pc_word = `PDR_RST_DATA;
      pc_word[WC-1:0] = pc_data_q;
      pc_word = merge16(pc_word, avs_writedata_i[15:0], wmask);
      pc_data_d = pc_data_q;
      if (wr_c)
         pc_data_d = pc_word[WC-1:0];
   end

   // no manual reset, standby or sleep input reaches these flops,
   // so software contents survive all of them
   // data registers, cleared only by power-on reset
   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         pa_data_q <= {WA{1'b0}};
         pb_data_q <= {WB{1'b0}};
         pc_data_q <= {WC{1'b0}};
      end else begin
         pa_data_q <= pa_data_d;
         pb_data_q <= pb_data_d;
         pc_data_q <= pc_data_d;
      end
   end

   // read word, reserved bits padded with zero
   always @* begin
      rdata_d = avs_readdata_o;
      if (rd_go) begin
         rdata_d = `PDR_RST_WORD;
         case (avs_address_i)
            `PDR_ADDR_A: begin
               rdata_d[WA-1:0] = pa_rd;
            end
            `PDR_ADDR_B: begin
               rdata_d[WB-1:0] = pb_rd;
            end
            `PDR_ADDR_C: begin
               rdata_d[WC-1:0] = pc_rd;
            end
            default: begin
               rdata_d = `PDR_RST_WORD;     // unmapped reads zero
            end
         endcase
      end
   end

   // waitrequest, high while idle
   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         avs_waitrequest_o <= 1'b1;
      end else begin
         avs_waitrequest_o <= wait_d;
      end
   end

   // read data, held until the next read is taken
   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         avs_readdata_o <= `PDR_RST_WORD;
      end else begin
         avs_readdata_o <= rdata_d;
      end
   end

   // mode 10 is never selected by software; the banks treat it as
   // input, undriven, so a stray code cannot fight the board
   // port a pins, mode codes
   pdr_pin_bank #(
      .W (WA)
   ) u_bank_a (
      .clk_i      (core_clk_i),
      .reset_i    (reset_i),
      .mode_i     (pa_mode_i),
      .data_i     (pa_data_q),
      .alt_out_i  (pa_alt_out_i),
      .pin_smp_i  (pa_smp_q),
      .pin_o      (pa_pin_o),
      .pin_oe_n_o (pa_pin_oe_n_o),
      .keep_o     (pa_keep_o),
      .rd_o       (pa_rd)
   );

   // port b pins
   pdr_pin_bank #(
      .W (WB)
   ) u_bank_b (
      .clk_i      (core_clk_i),
      .reset_i    (reset_i),
      .mode_i     (pb_mode_i),
      .data_i     (pb_data_q),
      .alt_out_i  (pb_alt_out_i),
      .pin_smp_i  (pb_smp_q),
      .pin_o      (pb_pin_o),
      .pin_oe_n_o (pb_pin_oe_n_o),
      .keep_o     (pb_keep_o),
      .rd_o       (pb_rd)
   );

   // port c pins, sixteen two-way pins
   pdr_pin_bank #(
      .W (WC)
   ) u_bank_c (
      .clk_i      (core_clk_i),
      .reset_i    (reset_i),
      .mode_i     (pc_mode_i),
      .data_i     (pc_data_q),
      .alt_out_i  (pc_alt_out_i),
      .pin_smp_i  (pc_smp_q),
      .pin_o      (pc_pin_o),
      .pin_oe_n_o (pc_pin_oe_n_o),
      .keep_o     (pc_keep_o),
      .rd_o       (pc_rd)
   );

endmodule // pdr_port_data
`default_nettype wire

// *** tb/pdr_port_data_monitor.sv ***
// Purpose: bus and pin checks of pdr_port_data
// Assumes: sees only the top ports
// Notes:   port a bit 0 and port c bit 15 stand for all pins
`timescale 1ns/1ps
`default_nettype none
`include "pdr_regs.vh"
module pdr_monitor #(
   parameter WA = 15,
   parameter WC = 16
) (
   // clock, reset and bus
   input wire logic            core_clk_i,
   input wire logic            reset_i,
   input wire logic [3:0]      avs_address_i,
   input wire logic            avs_read_i,
   input wire logic            avs_write_i,
   input wire logic [31:0]     avs_readdata_o,
   input wire logic            avs_waitrequest_o,
   // pins
   input wire logic [2*WA-1:0] pa_mode_i,
   input wire logic [WA-1:0]   pa_alt_out_i,
   input wire logic [WA-1:0]   pa_pin_i,
   input wire logic [WA-1:0]   pa_pin_oe_n_o,
   input wire logic [WA-1:0]   pa_keep_o,
   input wire logic [2*WC-1:0] pc_mode_i,
   input wire logic [WC-1:0]   pc_pin_oe_n_o
);
   // answer cycle of a read
   wire rda = avs_read_i && !avs_waitrequest_o;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (reset_i);
   property p_ws;
      (avs_read_i || avs_write_i) && avs_waitrequest_o
         |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
   endproperty
   a_ws: assert property (p_ws)
      else $error("wait state not one cycle");
   property p_rsv_a;
      rda && avs_address_i == `PDR_ADDR_A |-> avs_readdata_o[31:15] == 0;
   endproperty
   a_rsv_a: assert property (p_rsv_a)
      else $error("port a high bits not zero");
   property p_rsv_b;
      rda && avs_address_i == `PDR_ADDR_B |-> avs_readdata_o[31:9] == 0;
   endproperty
   a_rsv_b: assert property (p_rsv_b)
      else $error("port b high bits not zero");
   property p_rd_in;
      (pa_mode_i[1:0] == 2'h0 && $stable(pa_pin_i[0])) [*4] ##0
         (rda && avs_address_i == `PDR_ADDR_A)
         |-> avs_readdata_o[0] == pa_pin_i[0];
   endproperty
   a_rd_in: assert property (p_rd_in)
      else $error("input read not pin level");
   property p_oe_in;
      (pa_mode_i[1:0] == 2'h0) [*2] |-> pa_pin_oe_n_o[0];
   endproperty
   a_oe_in: assert property (p_oe_in)
      else $error("input pin driven");
   property p_oe_out;
      (pa_mode_i[1:0] == 2'h1) [*2] |-> !pa_pin_oe_n_o[0];
   endproperty
   a_oe_out: assert property (p_oe_out)
      else $error("output pin not driven");
   property p_keep_alt;
      (pa_mode_i[1:0] == 2'h3 && $stable(pa_alt_out_i[0])) [*3]
         |-> pa_keep_o[0] == pa_alt_out_i[0];
   endproperty
   a_keep_alt: assert property (p_keep_alt)
      else $error("keeper not alternate value");
   property p_c15;
      (pc_mode_i[31:30] == 2'h1) [*2] |-> !pc_pin_oe_n_o[15];
   endproperty
   a_c15: assert property (p_c15)
      else $error("port c pin 15 not driven");
endmodule // pdr_monitor
`default_nettype wire

// *** tb/pdr_board.sv ***
// Purpose: board side of one port
// Assumes: circuitry drives every pin the device leaves free
// Notes:   a driven pin shows the device value
`timescale 1ns/1ps
`default_nettype none
module pdr_board #(
   parameter W = 15
) (
   // device side and circuitry level
   input  wire logic [W-1:0] dev_i,
   input  wire logic [W-1:0] oe_n_i,
   input  wire logic [W-1:0] ext_i,
   // resolved pin level
   output wire logic [W-1:0] lvl_o
);
   // device wins where its enable is low
   assign lvl_o = (~oe_n_i & dev_i) | (oe_n_i & ext_i);
endmodule // pdr_board
`default_nettype wire

// *** tb/test_port_data_registers.sv ***
// Purpose: register and pin tests of pdr_port_data
// Assumes: bench drives modes in place of the function controller
// Notes:   boards drive every free pin
`timescale 1ns/1ps
`default_nettype none
`include "pdr_regs.vh"
module test_port_data_registers;
   logic        clk = 0, rst = 1, rd = 0, wr = 0, wq;
   logic [3:0]  adr = 0;
   logic [31:0] wd = 0, q, rdo, pcm = 0;
   logic [29:0] pam = 0;
   logic [17:0] pbm = 0;
   logic [14:0] ext = 0, alt = 0;
   wire  [14:0] pa_o, pa_oe, pa_k, pa_l;
   wire  [8:0]  pb_o, pb_oe, pb_l, pb_k;
   wire  [15:0] pc_o, pc_oe, pc_l, pc_k;
   int          errors = 0, comparisons = 0;
   // 40 MHz clock
   always #12.5 clk = ~clk;
   pdr_port_data dut (
      .core_clk_i(clk), .reset_i(rst), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_byteenable_i(4'hf), .avs_readdata_o(rdo),
      .avs_waitrequest_o(wq), .pa_mode_i(pam), .pa_alt_out_i(alt),
      .pa_pin_i(pa_l), .pa_pin_o(pa_o), .pa_pin_oe_n_o(pa_oe),
      .pa_keep_o(pa_k), .pb_mode_i(pbm), .pb_alt_out_i(alt[8:0]),
      .pb_pin_i(pb_l), .pb_pin_o(pb_o), .pb_pin_oe_n_o(pb_oe),
      .pb_keep_o(pb_k), .pc_mode_i(pcm), .pc_alt_out_i({alt, 1'b0}),
      .pc_pin_i(pc_l), .pc_pin_o(pc_o), .pc_pin_oe_n_o(pc_oe),
      .pc_keep_o(pc_k));
   pdr_board #(.W(15)) u_ba (.dev_i(pa_o), .oe_n_i(pa_oe),
      .ext_i(ext), .lvl_o(pa_l));
   pdr_board #(.W(9)) u_bb (.dev_i(pb_o), .oe_n_i(pb_oe),
      .ext_i(ext[8:0]), .lvl_o(pb_l));
   pdr_board #(.W(16)) u_bc (.dev_i(pc_o), .oe_n_i(pc_oe),
      .ext_i({ext, 1'b1}), .lvl_o(pc_l));
   task chk(input [31:0] seen, input [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one bus access, held until a rising edge sees waitrequest low
   task acc(input w, input [3:0] a, input [31:0] d);
      @(posedge clk);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      do @(posedge clk); while (wq !== 1'b0);
      q = rdo;
      wr <= 0;
      rd <= 0;
   endtask
   task rchk(input [3:0] a, input [31:0] exp);
      acc(0, a, 0);
      chk(q, exp);
   endtask
   // same mode on every pin, then let drive and keeper settle
   task setm(input [1:0] m);
      pam <= {15{m}};
      pbm <= {9{m}};
      pcm <= {16{m}};
      repeat (3) @(posedge clk);
   endtask
   task results;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (8) @(posedge clk);
      rst <= 0;
      setm(2'h1);
      rchk(`PDR_ADDR_A, `PDR_RST_WORD);
      rchk(`PDR_ADDR_B, `PDR_RST_WORD);
      rchk(4'hc, 32'h0000_0000);
      $display("reset test done");
      acc(1, `PDR_ADDR_A, 32'h0000_7fff);
      acc(1, `PDR_ADDR_B, 32'h0000_01ff);
      acc(1, `PDR_ADDR_C, 32'hffff_ffff);
      acc(1, 4'hc, 32'h0000_0000);
      rchk(`PDR_ADDR_A, 32'h0000_7fff);
      rchk(`PDR_ADDR_B, 32'h0000_01ff);
      rchk(`PDR_ADDR_C, 32'h0000_ffff);
      chk({pc_l, pb_l[7:0], pa_l[7:0]}, 32'hffff_ffff);
      $display("output test done");
      ext <= 15'h2a5a;
      setm(2'h0);
      acc(1, `PDR_ADDR_A, 32'h0000_1234);
      rchk(`PDR_ADDR_A, 32'h0000_2a5a);
      chk({17'h0, pa_oe}, 32'h0000_7fff);
      setm(2'h1);
      rchk(`PDR_ADDR_A, 32'h0000_1234);
      $display("input test done");
      alt <= 15'h5555;
      ext <= 15'h5555;
      setm(2'h0);
      setm(2'h3);
      chk({17'h0, pa_k}, 32'h0000_5555);
      acc(1, `PDR_ADDR_A, 32'h0000_3c3c);
      rchk(`PDR_ADDR_A, 32'h0000_5555);
      setm(2'h0);
      chk({17'h0, pa_k}, 32'h0000_3c3c);
      chk({pc_k, 7'h0, pb_k}, 32'hffff_01ff);
      $display("keeper test done");
      results;
   end
   // watchdog
   initial begin
      repeat (3000) @(posedge clk);
      errors++;
      results;
   end
endmodule // test_port_data_registers
bind pdr_port_data pdr_monitor #(.WA(WA), .WC(WC)) u_mon (
   .core_clk_i(core_clk_i), .reset_i(reset_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .pa_mode_i(pa_mode_i),
   .pa_alt_out_i(pa_alt_out_i), .pa_pin_i(pa_pin_i),
   .pa_pin_oe_n_o(pa_pin_oe_n_o), .pa_keep_o(pa_keep_o),
   .pc_mode_i(pc_mode_i), .pc_pin_oe_n_o(pc_pin_oe_n_o));
`default_nettype wire
